// [verilog/flag_unit_defs.svh]
`ifndef FLAG_UNIT_DEFS_SVH
`define FLAG_UNIT_DEFS_SVH

// instruction word: bit 0 of the printed numbering is word[23]
`define FRT_WORD_W 24
`define FRT_NFLAG 6
`define FRT_OPC_MSB 20
`define FRT_OPC_LSB 15
`define FRT_OPCODE 6'h12
`define FRT_B9 14
`define FRT_B10 13
`define FRT_B11 12
`define FRT_RST_MSB 11
`define FRT_SET_MSB 5
`define FRT_SUB_CLR_SET 3'h0
`define FRT_SUB_SET_CHK 3'h1
`define FRT_SUB_CLR_CHK 3'h2
`define FRT_SUB_DUAL 3'h3
`define FRT_FLAGS_RST 6'h00
`define FRT_CYC_NOSKIP 2'h1
`define FRT_CYC_SKIP 2'h2
`define FRT_OVF_BIT 0

`endif

// [verilog/flag_unit_pkg.sv]
`include "flag_unit_defs.svh"

package flag_unit_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXTRA = 2'b10
    } seq_state_e;

    typedef struct packed {
        logic done;
        logic skip;
        logic [1:0] cycles;
        logic reject;
    } result_s;

    typedef struct packed {
        seq_state_e st;
        logic [`FRT_NFLAG-1:0] flags;
        logic ready;
        result_s res;
    } unit_state_s;

endpackage

// [verilog/flag_register_test_unit.sv]
// Contract
// - six-position flag register; position one is overflow, rest free for program.
// - bit 9 zero acts on flags; bits 12-17 clear, 18-23 set.
// - bits 12/18 address indicator 1, onward through bits 17/23 indicator 6.
// - one machine cycle without skip, two cycles with skip.
// - bit 9 one makes both fields address the six sense switches.
// - bit 9 with bits 10/11 merges flag tests; never modifies flags.
// - the group cannot run under the repeat mechanism.
// - plain operation clears bits 12-17, sets bits 18-23, no skip.
// - plain operation complements a flag selected in both fields.
// - set-check: continue if any selected set flag is one, else skip.
// - set-check: afterwards clear every flag selected in bits 12-17.
// - clear-check: continue if any selected clear flag is zero, else skip.
// - clear-check: afterwards force every flag selected in bits 18-23 to one.
// - dual check skips only if no selected clear flag zero nor set flag one.
// - dual check: flag selected in both fields forces no skip.
// - dual check leaves every flag unchanged.
// - switch check skips unless selected clear switch off or set switch on.
// - switch selected in both fields forces no skip.
// - a switch that is on or lit reads as one.
`timescale 1ns/100ps
`default_nettype none
`include "flag_unit_defs.svh"

module flag_register_test_unit (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [`FRT_WORD_W-1:0] instr_word,
    input wire logic repeat_active,
    input wire logic [`FRT_NFLAG-1:0] sense_switches,
    input wire logic ovf_set,
    output logic instr_ready,
    output logic [`FRT_NFLAG-1:0] cond_indicators,
    output var flag_unit_pkg::result_s result
);

    logic rst_meta_q;
    logic rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    flag_unit_pkg::unit_state_s s_q;
    flag_unit_pkg::unit_state_s s_d;

    logic [`FRT_NFLAG-1:0] rst_sel;
    logic [`FRT_NFLAG-1:0] set_sel;
    logic [`FRT_NFLAG-1:0] sw_on;
    logic [`FRT_NFLAG-1:0] both_sel;
    logic [2:0] sub_op;
    logic sel_sw;
    logic sel_set_chk;
    logic sel_clr_chk;
    logic is_group;
    logic take;
    logic take_ok;
    logic hit_sw;
    logic hit_set;
    logic hit_clr;
    logic both_block;
    logic do_skip;
    logic [`FRT_NFLAG-1:0] new_flags;

    // field position k maps to indicator k+1
    // position mapping
    for (genvar i = 0; i < `FRT_NFLAG; i++) begin : g_map
        assign rst_sel[i] = instr_word[`FRT_RST_MSB - i];
        assign set_sel[i] = instr_word[`FRT_SET_MSB - i];
        assign sw_on[i] = sense_switches[i];
    end

    assign both_sel = rst_sel & set_sel;
    assign sub_op = instr_word[`FRT_B9:`FRT_B11];
    assign sel_sw = instr_word[`FRT_B9];
    assign sel_clr_chk = instr_word[`FRT_B10];
    assign sel_set_chk = instr_word[`FRT_B11];

    assign is_group = instr_word[`FRT_OPC_MSB:`FRT_OPC_LSB] == `FRT_OPCODE;
    assign take = instr_valid & s_q.ready & is_group;
    assign take_ok = take & ~repeat_active;

    assign hit_sw = |(rst_sel & ~sw_on) | |(set_sel & sw_on);
    assign hit_set = |(set_sel & s_q.flags & ~both_sel) |
        (~sel_clr_chk & |(set_sel & s_q.flags));
    assign hit_clr = |(rst_sel & ~s_q.flags & ~both_sel) |
        (~sel_set_chk & |(rst_sel & ~s_q.flags));

    always_comb begin
        both_block = 1'b0;
        if (sel_sw || (sel_set_chk && sel_clr_chk)) begin
            both_block = |both_sel;
        end
    end

    always_comb begin
        do_skip = 1'b0;
        if (sel_sw || sel_set_chk || sel_clr_chk) begin
            do_skip = 1'b1;
            if (sel_sw && hit_sw) begin
                do_skip = 1'b0;
            end
            if (sel_set_chk && hit_set) begin
                do_skip = 1'b0;
            end
            if (sel_clr_chk && hit_clr) begin
                do_skip = 1'b0;
            end
            if (both_block) begin
                do_skip = 1'b0;
            end
        end
    end

    always_comb begin
        new_flags = s_q.flags;
        if (!sel_sw) begin
            unique case (sub_op)
                `FRT_SUB_CLR_SET: begin
                    new_flags = (s_q.flags & ~rst_sel & ~set_sel) |
                        (set_sel & ~rst_sel) | (both_sel & ~s_q.flags);
                end
                `FRT_SUB_SET_CHK: begin
                    new_flags = s_q.flags & ~rst_sel;
                end
                `FRT_SUB_CLR_CHK: begin
                    new_flags = s_q.flags | set_sel;
                end
                `FRT_SUB_DUAL: begin
                    new_flags = s_q.flags;
                end
                default: begin
                    new_flags = s_q.flags;
                end
            endcase
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.res.done = 1'b0;
        s_d.res.reject = 1'b0;
        unique case (s_q.st)
            flag_unit_pkg::ST_IDLE: begin
                if (take) begin
                    if (repeat_active) begin
                        s_d.res.reject = 1'b1;
                    end else begin
                        s_d.flags = new_flags;
                        if (do_skip) begin
                            s_d.st = flag_unit_pkg::ST_EXTRA;
                            s_d.ready = 1'b0;
                        end else begin
                            s_d.res.done = 1'b1;
                            s_d.res.skip = 1'b0;
                            s_d.res.cycles = `FRT_CYC_NOSKIP;
                        end
                    end
                end
            end
            flag_unit_pkg::ST_EXTRA: begin
                s_d.st = flag_unit_pkg::ST_IDLE;
                s_d.ready = 1'b1;
                s_d.res.done = 1'b1;
                s_d.res.skip = 1'b1;
                s_d.res.cycles = `FRT_CYC_SKIP;
            end
            default: begin
                s_d.st = flag_unit_pkg::ST_IDLE;
                s_d.ready = 1'b1;
            end
        endcase
        if (ovf_set) begin
            s_d.flags[`FRT_OVF_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_q.st <= flag_unit_pkg::ST_IDLE;
            s_q.flags <= `FRT_FLAGS_RST;
            s_q.ready <= 1'b1;
            s_q.res <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign instr_ready = s_q.ready;
    assign cond_indicators = s_q.flags;
    assign result = s_q.res;

    property p_noskip_one;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take_ok && !do_skip |=>
            s_q.res.done && !s_q.res.skip && s_q.res.cycles == 2'h1 && s_q.ready;
    endproperty
    a_noskip_one: assert property (p_noskip_one)
        else $error("no-skip result not one cycle");

    property p_skip_two;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take_ok && do_skip |=> !s_q.res.done && !s_q.ready
            ##1 s_q.res.done && s_q.res.skip && s_q.res.cycles == 2'h2 && s_q.ready;
    endproperty
    a_skip_two: assert property (p_skip_two)
        else $error("skip result not on second cycle");

    property p_plain;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take_ok && !sel_sw && sub_op == 3'h0 && !ovf_set |=>
            s_q.res.done && !s_q.res.skip &&
            (s_q.flags & $past(rst_sel & ~set_sel)) == 6'h00 &&
            (s_q.flags & $past(set_sel & ~rst_sel)) == $past(set_sel & ~rst_sel);
    endproperty
    a_plain: assert property (p_plain)
        else $error("plain clear/set wrong");

    property p_toggle;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take_ok && !sel_sw && sub_op == 3'h0 && !ovf_set |=>
            (s_q.flags & $past(both_sel)) == ($past(~s_q.flags) & $past(both_sel));
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("doubly selected flag not toggled");

    property p_set_chk;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take_ok && !sel_sw && sub_op == 3'h1 && !ovf_set |=>
            (s_q.flags & $past(rst_sel)) == 6'h00 &&
            s_q.res.done == $past(|(set_sel & s_q.flags));
    endproperty
    a_set_chk: assert property (p_set_chk)
        else $error("set-check outcome or clear wrong");

    property p_clr_chk;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take_ok && !sel_sw && sub_op == 3'h2 |=>
            (s_q.flags & $past(set_sel)) == $past(set_sel) &&
            s_q.res.done == $past(|(rst_sel & ~s_q.flags));
    endproperty
    a_clr_chk: assert property (p_clr_chk)
        else $error("clear-check outcome or set wrong");

    property p_keep;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take && (sel_sw || sub_op == 3'h3 || repeat_active) && !ovf_set |=>
            $stable(s_q.flags);
    endproperty
    a_keep: assert property (p_keep)
        else $error("flags changed by a test-only form");

    property p_both;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take_ok && (sel_sw || sub_op == 3'h3) && (|both_sel) |=>
            s_q.res.done && !s_q.res.skip;
    endproperty
    a_both: assert property (p_both)
        else $error("doubly selected entry allowed a skip");

    property p_switch;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take_ok && sub_op == 3'h4 |=>
            s_q.res.done == $past(|(rst_sel & ~sense_switches) |
                |(set_sel & sense_switches) | |both_sel);
    endproperty
    a_switch: assert property (p_switch)
        else $error("switch test outcome wrong");

    property p_repeat;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take && repeat_active |=> s_q.res.reject && !s_q.res.done && s_q.ready;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("group ran under repeat");

    property p_ovf;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        ovf_set |=> s_q.flags[0];
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow position not set");

    property p_extra_one;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s_q.st == flag_unit_pkg::ST_EXTRA |->
            !s_q.ready ##1 (s_q.st == flag_unit_pkg::ST_IDLE && s_q.ready);
    endproperty
    a_extra_one: assert property (p_extra_one)
        else $error("extra cycle not exactly one");

    property p_dual;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take_ok && !sel_sw && sub_op == 3'h3 |=>
            s_q.res.done == $past(|both_sel |
                |(((rst_sel & ~s_q.flags) | (set_sel & s_q.flags)) & ~both_sel));
    endproperty
    a_dual: assert property (p_dual)
        else $error("dual test outcome wrong");

    property p_merged;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        take_ok && sub_op == 3'h7 |=>
            s_q.res.done == $past(|both_sel |
                |(rst_sel & (~sense_switches | ~s_q.flags)) |
                |(set_sel & (sense_switches | s_q.flags)));
    endproperty
    a_merged: assert property (p_merged)
        else $error("merged switch and flag test outcome wrong");

    property p_quiet;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !take && !ovf_set |=> $stable(s_q.flags);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("flags changed without an instruction");

endmodule // flag_register_test_unit
`default_nettype wire

// [sim/instr_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none

module instr_sequencer (
    input wire logic sys_clk,
    input wire logic instr_ready,
    input wire flag_unit_pkg::result_s result,
    output logic instr_valid,
    output logic [23:0] instr_word,
    output logic repeat_active
);
    initial begin
        instr_valid = 1'b0;
        instr_word = 24'h000000;
        repeat_active = 1'b0;
    end

    // offer a word, hold until taken, then count edges to the outcome
    task automatic issue(input logic [23:0] w, input logic r, output int n, output logic rej);
        int k;
        logic fin;
        k = 0;
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr_word = w;
        repeat_active = r;
        while (instr_ready !== 1'b1 && k < 50) begin
            @(negedge sys_clk);
            k++;
        end
        // take edge: outcome shows just after it, or one edge later on a skip
        @(posedge sys_clk);
        #1;
        n = 1;
        fin = result.done | result.reject;
        rej = result.reject;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        instr_word = ~w;
        repeat_active = 1'b0;
        while (fin !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
            fin = result.done | result.reject;
            rej = result.reject;
        end
    endtask
endmodule // instr_sequencer

`default_nettype wire

// [sim/flag_register_test_unit_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module flag_register_test_unit_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ovf_set = 1'b0;
    logic [5:0] sense_switches = 6'h00;
    logic instr_valid;
    logic repeat_active;
    logic [23:0] instr_word;
    logic instr_ready;
    logic [5:0] cond_indicators;
    flag_unit_pkg::result_s result;
    int errors = 0;
    int compares = 0;
    // rpt, sub, clear field, set field, switches
    localparam logic [21:0] TBL [12] = '{
        {1'b0, 3'h0, 6'h00, 6'h3f, 6'h00}, {1'b0, 3'h0, 6'h05, 6'h00, 6'h00},
        {1'b0, 3'h0, 6'h0f, 6'h0f, 6'h00}, {1'b0, 3'h1, 6'h01, 6'h0a, 6'h00},
        {1'b0, 3'h2, 6'h14, 6'h02, 6'h00}, {1'b0, 3'h3, 6'h04, 6'h08, 6'h00},
        {1'b0, 3'h3, 6'h01, 6'h01, 6'h00}, {1'b0, 3'h4, 6'h02, 6'h04, 6'h2a},
        {1'b0, 3'h4, 6'h01, 6'h01, 6'h2a}, {1'b0, 3'h7, 6'h01, 6'h00, 6'h2b},
        {1'b0, 3'h5, 6'h00, 6'h02, 6'h00}, {1'b1, 3'h0, 6'h00, 6'h3f, 6'h00}};

    always #4 sys_clk = ~sys_clk;

    flag_register_test_unit i_dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .instr_valid(instr_valid),
        .instr_word(instr_word),
        .repeat_active(repeat_active),
        .sense_switches(sense_switches),
        .ovf_set(ovf_set),
        .instr_ready(instr_ready),
        .cond_indicators(cond_indicators),
        .result(result)
    );

    instr_sequencer i_seq (
        .sys_clk(sys_clk),
        .instr_ready(instr_ready),
        .result(result),
        .instr_valid(instr_valid),
        .instr_word(instr_word),
        .repeat_active(repeat_active)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // indicator 1 sits in the leftmost bit of each field
    function automatic logic [23:0] mk(input logic [2:0] sb, input logic [5:0] c, input logic [5:0] s);
        mk = {3'h0, 6'h12, sb, 12'h000};
        for (int i = 0; i < 6; i++) begin
            mk[11-i] = c[i];
            mk[5-i] = s[i];
        end
    endfunction

    // returns {skip, new flags}
    function automatic logic [6:0] predict(input logic [5:0] f, input logic [5:0] sw,
            input logic [2:0] sb, input logic [5:0] c, input logic [5:0] s);
        logic [5:0] b;
        logic [5:0] m;
        b = c & s;
        m = ((~f & c) | (f & s)) & ~b;
        case (sb)
            3'h0: predict = {1'b0, (f & ~(c | s)) | (s & ~c) | (b & ~f)};
            3'h1: predict = {~|(f & s), f & ~c};
            3'h2: predict = {~|(~f & c), f | s};
            3'h3: predict = {~|b & ~|m, f};
            default: begin
                m = ((~sw & c) | (sw & s)) & ~b;
                if (sb[0]) m |= f & s & ~b;
                if (sb[1]) m |= ~f & c & ~b;
                predict = {~|b & ~|m, f};
            end
        endcase
    endfunction

    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        results();
    end

    initial begin
        logic rp;
        logic rej;
        logic [2:0] sb;
        logic [5:0] c;
        logic [5:0] s;
        logic [5:0] sw;
        logic [5:0] exp_f;
        logic [6:0] e;
        int n;
        exp_f = 6'h00;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(8'(cond_indicators), 8'h00);
        check(8'(instr_ready), 8'h01);
        check(8'(result), 8'h00);
        for (int i = 0; i < 12; i++) begin
            {rp, sb, c, s, sw} = TBL[i];
            @(negedge sys_clk);
            sense_switches = sw;
            e = predict(exp_f, sw, sb, c, s);
            i_seq.issue(mk(sb, c, s), rp, n, rej);
            check(8'(rej), 8'(rp));
            check(8'(cond_indicators), 8'(rp ? exp_f : e[5:0]));
            if (!rp) begin
                check(8'(result.skip), 8'(e[6]));
                check(8'(result.cycles), e[6] ? 8'h02 : 8'h01);
                exp_f = e[5:0];
            end
            check(8'(n), (!rp && e[6]) ? 8'h02 : 8'h01);
            $display("test %0d done", i);
        end
        @(negedge sys_clk);
        ovf_set = 1'b1;
        @(negedge sys_clk);
        ovf_set = 1'b0;
        check(8'(cond_indicators), 8'(exp_f | 6'h01));
        $display("overflow test done");
        results();
    end
endmodule // flag_register_test_unit_tb

`default_nettype wire
